/* tabh_map.svh */
// Purpose: register map and timing constants of the timer/alarm/hold block
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz core clock
// Notes:   definitions only
`ifndef TABH_MAP_SVH
`define TABH_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TABH_OFS_NS       8'h00
`define TABH_OFS_SEC      8'h04
`define TABH_OFS_ALARM    8'h08
`define TABH_OFS_HOLD     8'h0c
`define TABH_OFS_STATUS   8'h10
`define TABH_OFS_MASK     8'h14
`define TABH_OFS_CHIPIRQ  8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TABH_HOLD_BIT     0
`define TABH_FAULT_BIT    1
`define TABH_ST_ALARM     0
`define TABH_ST_FAULT     1
`define TABH_CHIP_ALARM   7
`define TABH_CHIP_FAULT   8

// ----------------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------------
`define TABH_NS_STEP      32'h0000_00c8
`define TABH_NS_WRAP      32'h3b9a_ca00
`define TABH_ALARM_STEP   32'h0000_00c8
`define TABH_TICK_NS      200
`define TABH_CLK_MHZ      200
`define TABH_TICK_CYC     ((`TABH_TICK_NS * `TABH_CLK_MHZ) / 1000)
`define TABH_HOLD_TICKS   2500
`define TABH_RST_WORD     32'h0000_0000

`endif

/* tabh_pkg.sv */
// Purpose: shared types of the timer/alarm/hold block
// Assumes: map constants in tabh_map.svh
// Notes:   types only
package tabh_pkg;

  typedef struct packed {
    logic [31:0] ns;
    logic [31:0] sec;
  } tabh_clock_type;

  typedef struct packed {
    logic hold;
    logic fault;
  } tabh_hold_type;

  typedef enum logic [1:0] {
    TABH_HOLD_IDLE  = 2'b00,
    TABH_HOLD_BUSY  = 2'b01,
    TABH_HOLD_FAULT = 2'b10
  } tabh_hold_state_type;

endpackage : tabh_pkg

/* tabh_tick.sv */
// Purpose: reference synchroniser and 200 ns tick generator
// Assumes: ref_5mhz is an asynchronous 5 MHz square wave
// Notes:   tick pulses one cycle per rising reference edge
`timescale 1ns/1ps
module tabh_tick (
  input  wire logic clk,        // core clock
  input  wire logic rst_sync_n, // synchronised reset
  input  wire logic ref_5mhz,   // reference from pin
  output logic      tick        // one-cycle 200 ns tick
);
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;

  // ----------------------------------------------------------------------
  // two-flop synchroniser, edge seen after
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      tick     <= 1'b0;
    end else begin
      ref_s1_q <= ref_5mhz;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      tick     <= ref_s2_q & ~ref_s3_q;
    end
  end
endmodule : tabh_tick

/* tabh_hold.sv */
// Purpose: bus-hold bit with half-millisecond watchdog
// Assumes: tick is a one-cycle 200 ns pulse
// Notes:   timeout clears hold and sets fault
`timescale 1ns/1ps
`include "tabh_map.svh"
module tabh_hold #(
  parameter int HOLD_TICKS = `TABH_HOLD_TICKS
) (
  input  wire logic clk,         // core clock
  input  wire logic rst_sync_n,  // synchronised reset
  input  wire logic tick,        // 200 ns tick
  input  wire logic wr_en,       // write to hold register
  input  wire logic wr_hold,     // written hold bit
  input  wire logic wr_fault_w1c,// written one to fault bit
  output tabh_pkg::tabh_hold_type state, // hold and fault
  output logic      fault_pulse  // one-cycle fault event (timeout or re-hold)
);
  logic [11:0]                   cnt_q;
  tabh_pkg::tabh_hold_state_type fsm_q;
  logic                          expire;
  logic                          rehold;

  assign expire = tick && (cnt_q == 12'(HOLD_TICKS - 1));
  assign rehold = wr_en && wr_hold;

  // ----------------------------------------------------------------------
  // hold state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fsm_q       <= tabh_pkg::TABH_HOLD_IDLE;
      cnt_q       <= 12'h000;
      fault_pulse <= 1'b0;
    end else begin
      fault_pulse <= 1'b0;
      case (fsm_q)
        tabh_pkg::TABH_HOLD_IDLE, tabh_pkg::TABH_HOLD_FAULT: begin
          if (rehold) begin
            fsm_q <= tabh_pkg::TABH_HOLD_BUSY;
            cnt_q <= 12'h000;
          end
        end
        tabh_pkg::TABH_HOLD_BUSY: begin
          if (rehold || expire) begin
            fsm_q       <= tabh_pkg::TABH_HOLD_FAULT;
            fault_pulse <= 1'b1;
          end else if (wr_en) begin
            fsm_q <= tabh_pkg::TABH_HOLD_IDLE;
          end else if (tick) begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        default: fsm_q <= tabh_pkg::TABH_HOLD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // fault flag, set wins over clear
  // ----------------------------------------------------------------------
  logic fault_q;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_q <= 1'b0;
    end else if (fault_pulse) begin
      fault_q <= 1'b1;
    end else if (wr_en && wr_fault_w1c) begin
      fault_q <= 1'b0;
    end
  end

  assign state.hold  = (fsm_q == tabh_pkg::TABH_HOLD_BUSY);
  assign state.fault = fault_q;
endmodule : tabh_hold

/* tabh_top.sv */
// Purpose: timer, alarm and bus-hold peripheral with AXI4-Lite slave
// Assumes: one 200 MHz clock, asynchronous 5 MHz reference pin
// Notes:   64-bit time read as ns word then latched seconds word
`timescale 1ns/1ps
`include "tabh_map.svh"

// Behaviour
// - Every 200 ns tick from the 5 MHz reference adds 200 to ns count.
// - At one thousand million ns the count wraps to zero, seconds +1.
// - Time is kept as a 32-bit ns and a 32-bit seconds register.
// - A read of ns latches seconds so the pair read is consistent.
// - The alarm register loses 200 at every tick, except when a bus write to it lands in the same cycle.
// - Alarm interrupt is high whenever the alarm top bit is set.
// - Writing hold one blocks the processor from the memory bus.
// - Hold not cleared within 2500 ticks raises fault, frees bus.
// - Writing hold one while held raises fault and frees the bus.
// - Hold register shows hold at bit 0 and fault at bit 1.
// - On timeout fault sets, hold clears and the processor proceeds.
// - The hold register is readable at any time.
// - Alarm-negative drives bit 7 of the chip interrupt vector.
// - Hold fault drives bit 8 of the chip interrupt vector.
module tabh_top #(
  parameter int HOLD_TICKS = `TABH_HOLD_TICKS
) (
  input  wire logic        clk,           // 200 MHz clock
  input  wire logic        rst_n,         // async reset, active low
  input  wire logic        ref_5mhz,      // 5 MHz reference pin
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic             mem_bus_block, // deny memory bus to processor
  output logic             alarm_irq,     // alarm negative level
  output logic             hold_fault_irq,// hold fault level
  output logic [17:0]      chip_irq_src,  // chip interrupt vector bits
  output logic             irq            // masked interrupt level
);
  // ----------------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------------
  logic rst_s1_q;
  logic rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // tick and hold submodules
  // ----------------------------------------------------------------------
  logic                    tick;
  tabh_pkg::tabh_hold_type hold_st;
  logic                    fault_pulse;
  logic                    hold_wr;
  logic [31:0]             wdata_m;

  tabh_tick u_tick (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .ref_5mhz   (ref_5mhz),
    .tick       (tick)
  );

  tabh_hold #(
    .HOLD_TICKS (HOLD_TICKS)
  ) u_hold (
    .clk          (clk),
    .rst_sync_n   (rst_sync_n),
    .tick         (tick),
    .wr_en        (hold_wr),
    .wr_hold      (wdata_m[`TABH_HOLD_BIT]),
    .wr_fault_w1c (wdata_m[`TABH_FAULT_BIT]),
    .state        (hold_st),
    .fault_pulse  (fault_pulse)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic tabh_mapped(input logic [7:0] a);
    case (a)
      `TABH_OFS_NS, `TABH_OFS_SEC, `TABH_OFS_ALARM, `TABH_OFS_HOLD,
      `TABH_OFS_STATUS, `TABH_OFS_MASK, `TABH_OFS_CHIPIRQ: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : tabh_mapped

  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;

  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= tabh_mapped(awaddr_q) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte-lane masked write data; unstrobed lanes write zero
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wdata_m[gi*8 +: 8] = wstrb_q[gi] ? wdata_q[gi*8 +: 8] : 8'h00;
    end
  endgenerate

  function automatic logic [31:0] tabh_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : tabh_merge

  logic alarm_wr;
  logic status_wr;
  logic mask_wr;
  assign hold_wr   = wr_go && (awaddr_q == `TABH_OFS_HOLD) && wstrb_q[0];
  assign alarm_wr  = wr_go && (awaddr_q == `TABH_OFS_ALARM);
  assign status_wr = wr_go && (awaddr_q == `TABH_OFS_STATUS);
  assign mask_wr   = wr_go && (awaddr_q == `TABH_OFS_MASK);

  // ----------------------------------------------------------------------
  // clock counters
  // ----------------------------------------------------------------------
  tabh_pkg::tabh_clock_type time_q;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      time_q <= {`TABH_RST_WORD, `TABH_RST_WORD};
    end else if (tick) begin
      if (time_q.ns + `TABH_NS_STEP >= `TABH_NS_WRAP) begin
        time_q.ns  <= `TABH_RST_WORD;
        time_q.sec <= time_q.sec + 32'h0000_0001;
      end else begin
        time_q.ns <= time_q.ns + `TABH_NS_STEP;
      end
    end
  end

  // ----------------------------------------------------------------------
  // alarm countdown
  // ----------------------------------------------------------------------
  logic [31:0] alarm_q;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alarm_q <= `TABH_RST_WORD;
    end else if (alarm_wr) begin
      alarm_q <= tabh_merge(alarm_q, wdata_q, wstrb_q);
    end else if (tick) begin
      alarm_q <= alarm_q - `TABH_ALARM_STEP;
    end
  end

  // ----------------------------------------------------------------------
  // sticky status, mask, outputs
  // ----------------------------------------------------------------------
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [1:0] ev;
  assign ev = {fault_pulse, alarm_q[31] && !alarm_irq};

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_q <= 2'b00;
      mask_q   <= 2'b00;
    end else begin
      status_q <= ev | (status_q & ~({2{status_wr}} & wdata_m[1:0]));
      if (mask_wr) begin
        mask_q <= wdata_m[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mem_bus_block  <= 1'b0;
      alarm_irq      <= 1'b0;
      hold_fault_irq <= 1'b0;
      chip_irq_src   <= 18'h00000;
      irq            <= 1'b0;
    end else begin
      mem_bus_block  <= hold_st.hold;
      alarm_irq      <= alarm_q[31];
      hold_fault_irq <= hold_st.fault;
      chip_irq_src   <= 18'h00000;
      chip_irq_src[`TABH_CHIP_ALARM] <= alarm_q[31];
      chip_irq_src[`TABH_CHIP_FAULT] <= hold_st.fault;
      irq            <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  logic [31:0] sec_latch_q;
  logic [31:0] rd_val;
  always_comb begin
    case (s_axi_araddr)
      `TABH_OFS_NS:      rd_val = time_q.ns;
      `TABH_OFS_SEC:     rd_val = sec_latch_q;
      `TABH_OFS_ALARM:   rd_val = alarm_q;
      `TABH_OFS_HOLD:    rd_val = {30'h0, hold_st.fault, hold_st.hold};
      `TABH_OFS_STATUS:  rd_val = {30'h0, status_q};
      `TABH_OFS_MASK:    rd_val = {30'h0, mask_q};
      `TABH_OFS_CHIPIRQ: rd_val = {14'h0, chip_irq_src};
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
      sec_latch_q   <= 32'h0000_0000;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= tabh_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        if (s_axi_araddr == `TABH_OFS_NS) begin
          sec_latch_q <= time_q.sec;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : tabh_top

/* tabh_properties.sv */
// Purpose: port-level checks of the timer/alarm/hold block
// Assumes: reference ticks every TICK_CYC core clocks
// Notes:   bound to every tabh_top instance
`timescale 1ns/1ps
module tabh_checker #(
  parameter int HOLD_TICKS = 2500,
  parameter int TICK_CYC   = 40
) (
  input wire logic        clk,            // core clock
  input wire logic        rst_n,          // async reset
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic [1:0]  s_axi_bresp,    // b response
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic        s_axi_bready,   // b ready
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic [31:0] s_axi_rdata,    // r data
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        s_axi_rready,   // r ready
  input wire logic        mem_bus_block,  // bus denied
  input wire logic        alarm_irq,      // alarm level
  input wire logic        hold_fault_irq, // hold fault level
  input wire logic [17:0] chip_irq_src    // chip vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] held_q; // cycles the bus has been denied
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) held_q <= 32'h0;
    else held_q <= mem_bus_block ? held_q + 32'h1 : 32'h0;
  end
  sequence s_w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_fault_rise;
    $rose(hold_fault_irq);
  endsequence
  a_write_answer: assert property (s_w_taken |-> ##[1:6] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  a_hold_bounded: assert property (
    held_q <= (HOLD_TICKS + 3) * TICK_CYC) else $error("hold too long");
  a_fault_frees_bus: assert property (
    s_fault_rise |-> ##[0:2] !mem_bus_block) else $error("bus kept");
  a_chip_alarm_bit: assert property (
    $rose(alarm_irq) |-> ##[0:2] chip_irq_src[7]) else $error("bit 7");
  a_chip_fault_bit: assert property (
    s_fault_rise |-> ##[0:2] chip_irq_src[8]) else $error("bit 8");
  a_chip_spare_zero: assert property (chip_irq_src[6:0] == 7'h0 &&
    chip_irq_src[17:9] == 9'h0) else $error("spare bit set");
endmodule : tabh_checker

bind tabh_top tabh_checker #(.HOLD_TICKS(HOLD_TICKS)) tabh_checker_inst (
  .clk(clk), .rst_n(rst_n), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .mem_bus_block(mem_bus_block),
  .alarm_irq(alarm_irq), .hold_fault_irq(hold_fault_irq),
  .chip_irq_src(chip_irq_src));

/* tabh_ref_model.sv */
// Purpose: 5 MHz reference source that can be paused
// Assumes: 200 MHz core clock
// Notes:   stopping freezes the level, so ticks can be counted
`timescale 1ns/1ps
module tabh_ref_model #(
  parameter int HALF_CYC = 20
) (
  input  wire logic clk,     // core clock
  input  wire logic run,     // oscillator running
  output logic      ref_5mhz // reference out
);
  int cnt;
  initial begin
    ref_5mhz = 1'b0;
    cnt = 0;
  end
  always @(posedge clk) begin
    if (run) begin
      cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
      if (cnt == HALF_CYC - 1) ref_5mhz <= ~ref_5mhz;
    end
  end
endmodule : tabh_ref_model

/* tabh_tb.sv */
// Purpose: self-checking bench of the timer/alarm/hold block
// Assumes: short hold window through HOLD_TICKS
// Notes:   the bench plays host software over AXI4-Lite
`timescale 1ns/1ps
`include "tabh_map.svh"
module tb;
  localparam int HT = 4;
  logic        clk = 1'b0, rst_n = 1'b0, run = 1'b0, ref_5mhz;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        mem_bus_block, alarm_irq, hold_fault_irq, irq;
  logic [17:0] chip_irq_src;
  logic [31:0] rnd = 32'hc6dae24a;
  int          errors = 0, cmp_count = 0, rise_cnt = 0, stall = 0;
  always #2.5 clk = ~clk;
  always @(posedge ref_5mhz) rise_cnt <= rise_cnt + 1;
  tabh_ref_model tabh_ref_model_inst (.clk(clk), .run(run),
    .ref_5mhz(ref_5mhz));
  tabh_top #(.HOLD_TICKS(HT)) tabh_top_inst (.clk(clk), .rst_n(rst_n),
    .ref_5mhz(ref_5mhz), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_bus_block(mem_bus_block),
    .alarm_irq(alarm_irq), .hold_fault_irq(hold_fault_irq),
    .chip_irq_src(chip_irq_src), .irq(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic timeout();
    errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    end_of_test();
  endtask : timeout
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_level(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_level
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        break;
      end
      if (n >= stall) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 40) timeout();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        break;
      end
      if (n >= stall) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (n == 40) timeout();
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk_word(d, e);
    chk_word({30'h0, r}, 32'h0);
  endtask : rd_chk
  // counts reference rises, then freezes the reference
  task automatic ticks(input int k);
    int t, n;
    t = rise_cnt + k;
    @(posedge clk) run <= 1'b1;
    for (n = 0; n < 100 * k && rise_cnt < t; n++) @(posedge clk);
    run <= 1'b0;
    if (rise_cnt < t) timeout();
    idle(8);
  endtask : ticks
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, d;
    logic [1:0]  r;
    int          i;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    idle(6);
    for (i = 0; i <= 'h18; i += 4) rd_chk(i[7:0], 32'h0);
    rd(8'h1c, d, r);
    chk_word({30'h0, r}, 32'h2);
    chk_word(d, 32'h0);
    wr(8'h1c, xs(), r);
    chk_word({30'h0, r}, 32'h2);
    $display("test reset_and_map done");
    for (i = 0; i < 10; i++) begin
      stall = i % 4;
      v = xs();
      if (i == 0) v = 32'h7fff_ffff;
      if (i == 1) v = 32'h8000_0000;
      wr(`TABH_OFS_ALARM, v, r);
      rd_chk(`TABH_OFS_ALARM, v);
      chk_level(alarm_irq, v[31]);
    end
    stall = 0;
    $display("test alarm_random done");
    wr(`TABH_OFS_ALARM, 32'h0000_0258, r);
    rd(`TABH_OFS_NS, v, r);
    ticks(3);
    rd_chk(`TABH_OFS_NS, v + 3 * `TABH_NS_STEP);
    rd_chk(`TABH_OFS_SEC, 32'h0);
    rd_chk(`TABH_OFS_ALARM, 32'h0);
    chk_level(alarm_irq, 1'b0);
    ticks(1);
    rd_chk(`TABH_OFS_ALARM, 32'h0258 - 4 * `TABH_ALARM_STEP);
    chk_level(alarm_irq, 1'b1);
    chk_level(chip_irq_src[7], 1'b1);
    $display("test countdown done");
    rd_chk(`TABH_OFS_STATUS, 32'h1);
    chk_level(irq, 1'b0);
    wr(`TABH_OFS_MASK, 32'h3, r);
    idle(2);
    chk_level(irq, 1'b1);
    wr(`TABH_OFS_ALARM, 32'h7fff_0000, r);
    wr(`TABH_OFS_STATUS, 32'h1, r);
    idle(2);
    rd_chk(`TABH_OFS_STATUS, 32'h0);
    chk_level(irq, 1'b0);
    chk_level(alarm_irq, 1'b0);
    $display("test interrupt done");
    wr(`TABH_OFS_HOLD, 32'h1, r);
    idle(2);
    chk_level(mem_bus_block, 1'b1);
    rd_chk(`TABH_OFS_HOLD, 32'h1);
    wr(`TABH_OFS_HOLD, 32'h0, r);
    idle(2);
    chk_level(mem_bus_block, 1'b0);
    wstrb <= 4'he;
    wr(`TABH_OFS_HOLD, 32'h1, r);
    wstrb <= 4'hf;
    idle(2);
    chk_level(mem_bus_block, 1'b0);
    wr(`TABH_OFS_HOLD, 32'h1, r);
    ticks(HT - 1);
    chk_level(mem_bus_block, 1'b1);
    ticks(3);
    chk_level(mem_bus_block, 1'b0);
    chk_level(hold_fault_irq, 1'b1);
    chk_level(chip_irq_src[8], 1'b1);
    chk_level(irq, 1'b1);
    rd_chk(`TABH_OFS_HOLD, 32'h2);
    rd_chk(`TABH_OFS_STATUS, 32'h2);
    wr(`TABH_OFS_HOLD, 32'h2, r);
    idle(2);
    rd_chk(`TABH_OFS_HOLD, 32'h0);
    wr(`TABH_OFS_HOLD, 32'h1, r);
    wr(`TABH_OFS_HOLD, 32'h1, r);
    idle(2);
    chk_level(mem_bus_block, 1'b0);
    chk_level(hold_fault_irq, 1'b1);
    rd_chk(`TABH_OFS_HOLD, 32'h2);
    $display("test hold done");
    end_of_test();
  end
endmodule : tb
